// File: core/plc_pkg.sv
/*
  Constants for the link control register block: offset, field positions,
  power-state encodings and latency selection.
  Assumes a 16-bit register reached through configuration space accesses.
*/
package plc_pkg;
  localparam logic [11:0] LINK_CONTROL_OFS = 12'h0B0;
  localparam int REG_W = 16;
  // Field positions
  localparam int ASPM_LO = 0;
  localparam int ASPM_HI = 1;
  localparam int RCB_BIT = 3;
  localparam int CCLK_BIT = 6;
  localparam int XSYNC_BIT = 7;
  localparam logic [15:0] WR_MASK = 16'h00CB;
  localparam logic [15:0] RESET_VAL = 16'h0000;
  // Power state entry encodings
  localparam logic [1:0] ASPM_OFF = 2'h0;
  localparam logic [1:0] ASPM_L0S = 2'h1;
  localparam logic [1:0] ASPM_L1 = 2'h2;
  localparam logic [1:0] ASPM_BOTH = 2'h3;
  localparam logic [2:0] LAT_W = 3'h3;
  // Link power states
  typedef enum logic [1:0] {PLC_L0, PLC_L0S, PLC_L1} plc_pstate_e;
endpackage

// File: core/plc_ctl_if.sv
/*
  Control bundle between the register file and the link power controller.
  Assumes both ends run on clk_sys.
*/
`timescale 1ns/1ns
interface plc_ctl_if;
  logic [1:0] aspm;
  logic common_clk;
  logic ext_sync;
  logic [2:0] l0s_lat;
  modport regs (output aspm, output common_clk, output ext_sync,
    output l0s_lat);
  modport pm (input aspm, input common_clk, input ext_sync,
    input l0s_lat);
endinterface

// File: core/plc_pm.sv
/*
  Link power controller: picks L0s or L1 entry from idle requests, gated by
  the power state entry field; drives fast-training exit sequence length.
  Assumes requests come from logic on clk_sys.
*/
`timescale 1ns/1ns
module plc_pm (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rstn,
  // Controls from the register
  plc_ctl_if.pm ctl,
  // Requests
  input wire logic tx_idle_l0s,
  input wire logic idle_l1,
  input wire logic wake,
  // Status
  output logic [1:0] pstate,
  output logic ext_exit,
  output logic [2:0] exit_lat
);
  plc_pkg::plc_pstate_e st_q, st_d;
  logic xs_q, xs_d;
  logic [2:0] lat_q, lat_d;

  always_comb begin
    st_d = st_q;
    xs_d = 1'b0;
    lat_d = ctl.l0s_lat;  // RL8
    case (st_q)
      plc_pkg::PLC_L0: begin
        // Never enter a state the field forbids
        if (idle_l1 && ctl.aspm[1]) begin  // RL13
          st_d = plc_pkg::PLC_L1;
        end else if (tx_idle_l0s && ctl.aspm[0]) begin  // RL13
          st_d = plc_pkg::PLC_L0S;
        end
      end
      plc_pkg::PLC_L0S: begin
        if (wake) begin
          st_d = plc_pkg::PLC_L0;
          xs_d = ctl.ext_sync;  // RL9
        end
      end
      plc_pkg::PLC_L1: begin
        if (wake) begin
          st_d = plc_pkg::PLC_L0;
        end
      end
      default: st_d = plc_pkg::PLC_L0;
    endcase
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      st_q <= plc_pkg::PLC_L0;
      xs_q <= 1'b0;
      lat_q <= 3'h0;
    end else begin
      st_q <= st_d;
      xs_q <= xs_d;
      lat_q <= lat_d;
    end
  end

  assign pstate = st_q;
  assign ext_exit = xs_q;
  assign exit_lat = lat_q;
endmodule

// File: core/plc_link_ctrl.sv
/*
  Link control configuration register of an endpoint with its power
  controller. Holds power state entry control, completion boundary,
  common clock and extended sync bits.
  Assumes single-cycle config write/read strobes on clk_sys.
*/
// Notes on behaviour
// [RL1] Bits 1:0 writable: off, L0s, L1, or both entry allowed.
// [RL2] Receiver may still enter L0s whatever the field says.
// [RL3] Function reset keeps bits 1:0, 6 and 7; full reset clears them.
// [RL4] Bit 3 writable completion boundary, zero is 64 byte, one 128.
// [RL5] Software sets bit 3 only if root port reports 128 byte.
// [RL6] Bits 4 and 5 read-only zero for endpoints.
// [RL7] Bit 6 writable, set means common reference clock with partner.
// [RL8] Common clock bit selects L0s exit latency used and reported.
// [RL9] Bit 7 set: extended fast training plus extra TS1 on L0s exit.
// [RL10] Bits 8 through 11 read-only zero.
// [RL11] L0s exit latency loaded from config, per clock mode.
// [RL12] Reserved and read-only bits ignore writes, read zero.
// [RL13] Power controller never enters a state the field forbids.
`timescale 1ns/1ns
module plc_link_ctrl (
  // Clock and resets
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic flr,
  // Configuration access
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [11:0] cfg_addr,
  input wire logic [15:0] cfg_wdata,
  input wire logic [1:0] cfg_be,
  output logic [15:0] cfg_rdata,
  output logic cfg_ack,
  // Latencies from non-volatile config
  input wire logic [2:0] nv_lat_common,
  input wire logic [2:0] nv_lat_sep,
  // Link power side
  input wire logic tx_idle_l0s,
  input wire logic idle_l1,
  input wire logic wake,
  input wire logic rx_idle,
  output logic [1:0] pstate,
  output logic ext_exit,
  output logic [2:0] l0s_exit_lat,
  output logic rx_l0s,
  output logic rcb_128
);
  plc_ctl_if ctl ();
  logic [15:0] reg_q, reg_d, wmask;
  logic [15:0] rd_q, rd_d;
  logic ack_q, ack_d, rxl_q, rxl_d;
  logic [2:0] lat_q, lat_d;
  logic hit;

  // ==========================================================
  // Register write
  // ==========================================================
  assign hit = (cfg_addr == plc_pkg::LINK_CONTROL_OFS);
  assign wmask = plc_pkg::WR_MASK & {{8{cfg_be[1]}}, {8{cfg_be[0]}}};

  always_comb begin
    reg_d = reg_q;
    if (flr) begin
      // Only the completion boundary clears; the rest survive  RL3
      reg_d[plc_pkg::RCB_BIT] = 1'b0;  // RL3
    end else if (cfg_wr && hit) begin
      // Read-only and reserved bits never take write data
      reg_d = (reg_q & ~wmask) | (cfg_wdata & wmask);  // RL1 RL4 RL7 RL12
    end
    reg_d = reg_d & plc_pkg::WR_MASK;  // RL6 RL10 RL12
  end

  // ==========================================================
  // Read path and latency select
  // ==========================================================
  always_comb begin
    rd_d = 16'h0000;
    ack_d = cfg_wr | cfg_rd;
    if (cfg_rd && hit) begin
      rd_d = reg_q;  // RL6 RL10 RL12
    end
    // Latency follows the clock mode bit  RL8
    lat_d = reg_q[plc_pkg::CCLK_BIT] ? nv_lat_common : nv_lat_sep;  // RL11
    // Receiver L0s is independent of the transmit enable field
    rxl_d = rx_idle & ~wake;  // RL2
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      reg_q <= plc_pkg::RESET_VAL;  // RL3
      rd_q <= 16'h0000;
      ack_q <= 1'b0;
      lat_q <= 3'h0;
      rxl_q <= 1'b0;
    end else begin
      reg_q <= reg_d;
      rd_q <= rd_d;
      ack_q <= ack_d;
      lat_q <= lat_d;
      rxl_q <= rxl_d;
    end
  end

  assign ctl.aspm = reg_q[plc_pkg::ASPM_HI:plc_pkg::ASPM_LO];
  assign ctl.common_clk = reg_q[plc_pkg::CCLK_BIT];
  assign ctl.ext_sync = reg_q[plc_pkg::XSYNC_BIT];
  assign ctl.l0s_lat = lat_q;

  // ==========================================================
  // Power controller
  // ==========================================================
  plc_pm u_pm (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .ctl(ctl),
    .tx_idle_l0s(tx_idle_l0s),
    .idle_l1(idle_l1),
    .wake(wake),
    .pstate(pstate),
    .ext_exit(ext_exit),
    .exit_lat(l0s_exit_lat)
  );

  assign cfg_rdata = rd_q;
  assign cfg_ack = ack_q;
  assign rx_l0s = rxl_q;
  // Boundary is only a hint to the requester; software keeps it honest  RL5
  assign rcb_128 = reg_q[plc_pkg::RCB_BIT];
endmodule

// File: tb/plc_cfg_sw.sv
/* Software model: writes the completion boundary only when allowed.
   Assumes the bench asks for values and supplies the root port's ability. */
`timescale 1ns/1ns
module plc_cfg_sw (
  // Root port ability and wanted value
  input wire logic cap,
  input wire logic [15:0] want,
  // Value really written
  output logic [15:0] wdata
);
  assign wdata = cap ? want : (want & 16'hFFF7);
endmodule

// File: tb/plc_link_ctrl_asserts.sv
/* Checker for the link control block, on its top ports only.
   Assumes one clk_sys domain with rstn as its reset. */
`timescale 1ns/1ns
module plc_link_ctrl_asserts (
  // Clock and resets
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic flr,
  // Config and power side
  input wire logic cfg_wr,
  input wire logic cfg_rd,
  input wire logic [15:0] cfg_rdata,
  input wire logic cfg_ack,
  input wire logic tx_idle_l0s,
  input wire logic idle_l1,
  input wire logic wake,
  input wire logic rx_idle,
  input wire logic [1:0] pstate,
  input wire logic ext_exit,
  input wire logic rx_l0s,
  input wire logic rcb_128
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  sequence req_s; cfg_wr || cfg_rd; endsequence
  sequence flr2_s; flr [*2]; endsequence
  ack_timing_a: assert property (req_s |=> cfg_ack)
    else $error("no answer after access");
  quiet_bus_a: assert property (!(cfg_wr || cfg_rd) |=>
    !cfg_ack && cfg_rdata == 16'h0000) else $error("stray answer");
  ro_zero_a: assert property (cfg_ack |->
    (cfg_rdata & 16'hFF34) == 16'h0000) else $error("fixed bit set");
  flr_rcb_a: assert property (flr2_s |=> !rcb_128)
    else $error("boundary kept over function reset");
  stay_l0_a: assert property (pstate == 2'h0 && !idle_l1 &&
    !tx_idle_l0s |=> pstate == 2'h0) else $error("left L0 unasked");
  wake_exit_a: assert property (pstate != 2'h0 && wake |=>
    pstate == 2'h0) else $error("no return to L0");
  ext_pulse_a: assert property (ext_exit |-> pstate == 2'h0 &&
    $past(pstate) == 2'h1) else $error("extended exit out of place");
  rx_track_a: assert property (rx_idle && !wake |=> rx_l0s)
    else $error("receiver kept out of L0s");
endmodule
bind plc_link_ctrl plc_link_ctrl_asserts u_chk (.clk_sys(clk_sys),
  .rstn(rstn), .flr(flr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
  .cfg_rdata(cfg_rdata), .cfg_ack(cfg_ack), .tx_idle_l0s(tx_idle_l0s),
  .idle_l1(idle_l1), .wake(wake), .rx_idle(rx_idle), .pstate(pstate),
  .ext_exit(ext_exit), .rx_l0s(rx_l0s), .rcb_128(rcb_128));

// File: tb/plc_link_ctrl_tb.sv
/* Bench for plc_link_ctrl: accesses, resets and power moves.
   Assumes the checker is bound from its own file. */
`timescale 1ns/1ns
module plc_link_ctrl_tb;
  logic clk_sys, rstn, flr, cfg_wr, cfg_rd, tx_idle_l0s, idle_l1, wake;
  logic rx_idle, ext_exit, rx_l0s, rcb_128, cfg_ack, cap;
  logic [11:0] cfg_addr;
  logic [15:0] cfg_wdata, cfg_rdata, want, sw_data;
  logic [1:0] cfg_be, pstate, ex;
  logic [2:0] nv_c, nv_s, lat;
  int failures, check_count;
  plc_link_ctrl DUT (.clk_sys(clk_sys), .rstn(rstn), .flr(flr),
    .cfg_wr(cfg_wr), .cfg_rd(cfg_rd), .cfg_addr(cfg_addr),
    .cfg_wdata(cfg_wdata), .cfg_be(cfg_be), .cfg_rdata(cfg_rdata),
    .cfg_ack(cfg_ack), .nv_lat_common(nv_c), .nv_lat_sep(nv_s),
    .tx_idle_l0s(tx_idle_l0s), .idle_l1(idle_l1), .wake(wake),
    .rx_idle(rx_idle), .pstate(pstate), .ext_exit(ext_exit),
    .l0s_exit_lat(lat), .rx_l0s(rx_l0s), .rcb_128(rcb_128));
  plc_cfg_sw SW (.cap(cap), .want(want), .wdata(sw_data));
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  function logic [1:0] exp_state(input logic [1:0] a, m);
    return (m[1] & a[1]) ? 2'h2 : (m[0] & a[0]) ? 2'h1 : 2'h0;
  endfunction
  task chk(input string n, input logic [15:0] s, e);
    check_count++;
    if (s !== e) begin
      failures++;
      $display("[FAIL] %s expected %h seen %h", n, e, s);
    end
  endtask
  task wr(input logic [11:0] a, input logic [15:0] d, input logic [1:0] b);
    @(posedge clk_sys);
    {cfg_wr, cfg_addr, cfg_wdata, cfg_be} <= {1'b1, a, d, b};
    @(posedge clk_sys);
    cfg_wr <= 1'b0;
  endtask
  task rd(input logic [11:0] a, input logic [15:0] e);
    @(posedge clk_sys);
    {cfg_rd, cfg_addr} <= {1'b1, a};
    @(posedge clk_sys);
    cfg_rd <= 1'b0;
    #1 chk("rdata", cfg_rdata, e);
  endtask
  task print_verdict;
    $display("checks %0d failures %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clk_sys);
    failures++;
    print_verdict;
  end
  initial begin
    void'($urandom(65));
    {rstn, flr, cfg_wr, cfg_rd, tx_idle_l0s, idle_l1, wake} = 7'h00;
    {rx_idle, cap, cfg_addr, cfg_wdata, cfg_be, want} = 48'h0;
    nv_c = 3'($urandom);
    nv_s = ~nv_c;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(12'h0B0, plc_pkg::RESET_VAL);
    for (int i = 0; i < 20; i++) begin
      want = 16'($urandom);
      cap = 1'($urandom);
      #1 wr(12'h0B0, sw_data, 2'h3);
      rd(12'h0B0, sw_data & plc_pkg::WR_MASK);
    end
    wr(12'h0B0, 16'hFFF7, 2'h1);
    wr(12'h0B0, 16'h0000, 2'h2);
    wr(12'h0B2, 16'h0000, 2'h3);
    rd(12'h0B0, 16'h00C3);
    rd(12'h0AC, 16'h0000);
    {cap, want} = 17'h1FFFF;
    #1 wr(12'h0B0, sw_data, 2'h3);
    @(posedge clk_sys) #1 chk("rcb", 16'(rcb_128), 16'h0001);
    @(posedge clk_sys) flr <= 1'b1;
    repeat (2) @(posedge clk_sys);
    flr <= 1'b0;
    rd(12'h0B0, 16'h00C3);
    chk("rcb", 16'(rcb_128), 16'h0000);
    for (int c = 0; c < 2; c++) begin
      wr(12'h0B0, 16'(c << 6), 2'h3);
      repeat (3) @(posedge clk_sys);
      #1 chk("lat", 16'(lat), 16'(c ? nv_c : nv_s));
    end
    for (int a = 0; a < 4; a++) begin
      for (int m = 1; m < 4; m++) begin
        // Extended sync only on the passes that request L1, so both settings
        // of bit 7 meet an L0s exit
        wr(12'h0B0, 16'(a | (m & 2) << 6), 2'h3);
        @(posedge clk_sys) {idle_l1, tx_idle_l0s} <= 2'(m);
        repeat (2) @(posedge clk_sys);
        ex = exp_state(2'(a), 2'(m));
        #1 chk("pstate", 16'(pstate), 16'(ex));
        @(posedge clk_sys) {idle_l1, tx_idle_l0s, wake} <= 3'h1;
        @(posedge clk_sys) #1 chk("ext", 16'(ext_exit),
          16'(ex == 2'h1 && m > 1));
        @(posedge clk_sys) wake <= 1'b0;
      end
    end
    // Transmit entry limited to L1, yet the receiver still idles
    wr(12'h0B0, 16'h00CA, 2'h3);
    rx_idle <= 1'b1;
    repeat (2) @(posedge clk_sys);
    #1 chk("rx_l0s", 16'(rx_l0s), 16'h0001);
    // Full reset, unlike a function reset, restores every field
    @(posedge clk_sys) {rx_idle, rstn} <= 2'b00;
    repeat (3) @(posedge clk_sys);
    rstn <= 1'b1;
    rd(12'h0B0, plc_pkg::RESET_VAL);
    chk("rcb", 16'(rcb_128), 16'h0000);
    print_verdict;
  end
endmodule
